// File: rtl/vbit_transducer.sv
// Valve and binary input transducer with AXI4-Lite register access.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "vbit_map.svh"
// ======================================================================
// Contract
// - Setpoint zero means closed, nonzero open.
// - Accept setpoint only with good status.
// - Bad or uncertain status de-energizes valve drive.
// - High feedback current is one, low zero.
// - Decode open/intermediate/closed by sensor assignment.
// - Intermediate extended by commanded direction.
// - Return 8-bit readback value with status.
// - Keep stroke, cyclic test, actuation-pending flags.
// - Block alarm is OR of all faults.
// - Forward all faults but config error.
// - Drive faults output failure, contact faults input failure.
// - Two input groups scanned independently.
// - Group one on-times 10..11000 ms, summed.
// - Group two 10 ms slots, minimum 50 ms.
// - Group one byte holds channels 1,4,7,10.
// - Group two byte holds eight channels in order.
// - Route inputs by channel number.
// - Packed values report good status on lead faults.
// - Packed values bad only on device failure.
// - Pass values after stable for filter time.
// - Disabled group one channel skipped, no time.
module vbit_transducer #(
  parameter int TICK_CYCLES = `VBIT_TICK_TIME_NS / `VBIT_CLK_PERIOD_NS
) (
  input wire logic CLK_SYS_I, // System clock, 100 MHz.
  input wire logic ARST_N_I, // Asynchronous reset, active low.
  input wire logic [7:0] S_AXI_AWADDR, // Write address.
  input wire logic S_AXI_AWVALID, // Write address valid.
  output logic S_AXI_AWREADY, // Write address ready.
  input wire logic [31:0] S_AXI_WDATA, // Write data.
  input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
  input wire logic S_AXI_WVALID, // Write data valid.
  output logic S_AXI_WREADY, // Write data ready.
  output logic [1:0] S_AXI_BRESP, // Write response.
  output logic S_AXI_BVALID, // Write response valid.
  input wire logic S_AXI_BREADY, // Write response ready.
  input wire logic [7:0] S_AXI_ARADDR, // Read address.
  input wire logic S_AXI_ARVALID, // Read address valid.
  output logic S_AXI_ARREADY, // Read address ready.
  output logic [31:0] S_AXI_RDATA, // Read data.
  output logic [1:0] S_AXI_RRESP, // Read response.
  output logic S_AXI_RVALID, // Read data valid.
  input wire logic S_AXI_RREADY, // Read data ready.
  input wire logic FB_A_HIGH_I, // Contact A high current.
  input wire logic FB_B_HIGH_I, // Contact B high current.
  input wire logic VALVE_LEAD_FAULT_I, // Valve lead broken or shorted.
  input wire logic TRANSIT_FAULT_I, // Valve transit time exceeded.
  input wire logic SENSOR_LEAD_FAULT_I, // Sensor lead fault.
  input wire logic CONFIG_ERR_I, // Configuration error.
  input wire logic HW_FAIL_I, // Hardware failure.
  input wire logic STROKE_LIMIT_I, // Stroke limit exceeded.
  input wire logic CYCLIC_TEST_I, // Cyclic test running.
  input wire logic G1_SENSE_HIGH_I, // Group one sense.
  input wire logic G2_SENSE_HIGH_I, // Group two sense.
  output logic VALVE_DRIVE_O, // Valve drive energized.
  output logic [3:0] G1_POWER_O, // Group one power, one-hot.
  output logic [7:0] G2_SELECT_O, // Group two select, one-hot.
  output logic BLOCK_ALARM_O, // Block alarm.
  output vbit_pkg::vbit_err_s DO_BLOCK_ERR_O, // Output block error word.
  output vbit_pkg::vbit_val_s READBACK_O // Position readback.
);
  import vbit_pkg::*;

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
  localparam logic [3:0] G2_SLOT_LAST = 4'(`VBIT_G2_SLOT_MS - 1);
  localparam logic [3:0] G2_MIN_SLOTS = 4'(`VBIT_G2_MIN_CYCLE_MS / `VBIT_G2_SLOT_MS);

  // ======================================================================
  // Helper functions
  // Clamp an on-time so a zero never stalls the scan.
  function automatic logic [15:0] sat_ontime(input logic [15:0] t);
    if (t < `VBIT_ONT_MIN_MS) begin
      return `VBIT_ONT_MIN_MS;
    end else if (t > `VBIT_ONT_MAX_MS) begin
      return `VBIT_ONT_MAX_MS;
    end
    return t;
  endfunction

  // Good, cascade or not.
  function automatic logic is_good(input logic [7:0] st);
    return st[7:6] == `VBIT_Q_GOOD_NC || st[7:6] == `VBIT_Q_GOOD_CAS;
  endfunction

  // ======================================================================
  // Registers and state
  logic [31:0] ctrl_reg;
  vbit_val_s setp_reg;
  logic [15:0] ont_reg [4];
  logic [15:0] ftime_reg;
  logic [8:0] route_reg;
  logic aw_have_reg, w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [16:0] tick_cnt_reg;
  logic tick_reg;
  logic fb_a_reg, fb_b_reg;
  logic cmd_open_reg;
  logic pending_reg;
  vbit_pos_e pos_reg;
  vbit_ext_e ext_reg;
  logic [1:0] g1_idx_reg;
  logic [15:0] g1_cnt_reg;
  logic [3:0] g1_raw_reg;
  vbit_g2_e g2_state_reg;
  logic [2:0] g2_idx_reg;
  logic [3:0] g2_cnt_reg, g2_used_reg, g2_pad_reg;
  logic [7:0] g2_raw_reg;
  logic [7:0] flt_last_reg [2];
  logic [7:0] flt_pv_reg [2];
  logic [25:0] flt_cnt_reg [2];
  vbit_val_s route_val_reg;

  wire logic valve_mode = ~ctrl_reg[`VBIT_CTRL_MODE_BIT];
  wire logic [1:0] usage = ctrl_reg[`VBIT_CTRL_USAGE_LSB +: 2];
  wire logic [3:0] g1_en = ctrl_reg[`VBIT_CTRL_G1EN_LSB +: 4];
  wire logic [7:0] g2_en = ctrl_reg[`VBIT_CTRL_G2EN_LSB +: 8];
  wire logic [7:0] g1_byte = {4'h0, g1_raw_reg};
  wire logic [7:0] vstat = {pending_reg, CYCLIC_TEST_I, STROKE_LIMIT_I, 1'b0, ext_reg, pos_reg};

  // ======================================================================
  // AXI4-Lite slave
  // Address and data latch apart, so either may come first.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      S_AXI_BVALID <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (aw_have_reg && w_have_reg && !S_AXI_BVALID) begin
        S_AXI_BVALID <= 1'b1;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
    end
  end

  // Registered readies drop the cycle after their beat is taken.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_have_reg && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY <= !w_have_reg && !(S_AXI_WVALID && S_AXI_WREADY);
    end
  end

  // Register writes land as the response is raised.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_reg <= `VBIT_CTRL_RST;
      setp_reg <= 16'h0000;
      ont_reg <= '{default: `VBIT_ONT_RST};
      ftime_reg <= `VBIT_FTIME_RST;
      route_reg <= `VBIT_ROUTE_RST;
    end else if (aw_have_reg && w_have_reg && !S_AXI_BVALID) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_reg[b]) begin
          case (aw_addr_reg)
            `VBIT_CTRL_OFS: ctrl_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
            `VBIT_SETP_OFS: if (b < 2) setp_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
            `VBIT_ONT01_OFS: ont_reg[b/2][(b%2)*8 +: 8] <= w_data_reg[b*8 +: 8];
            `VBIT_ONT23_OFS: ont_reg[2+b/2][(b%2)*8 +: 8] <= w_data_reg[b*8 +: 8];
            `VBIT_FTIME_OFS: if (b < 2) ftime_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
            `VBIT_ROUTE_OFS: begin
              if (b == 0) route_reg[7:0] <= w_data_reg[7:0];
              if (b == 1) route_reg[8] <= w_data_reg[8];
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Reads; unmapped addresses answer zero, OKAY.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        case (S_AXI_ARADDR)
          `VBIT_CTRL_OFS: S_AXI_RDATA <= ctrl_reg;
          `VBIT_SETP_OFS: S_AXI_RDATA <= {16'h0000, setp_reg};
          `VBIT_ONT01_OFS: S_AXI_RDATA <= {ont_reg[1], ont_reg[0]};
          `VBIT_ONT23_OFS: S_AXI_RDATA <= {ont_reg[3], ont_reg[2]};
          `VBIT_FTIME_OFS: S_AXI_RDATA <= {16'h0000, ftime_reg};
          `VBIT_VSTAT_OFS: S_AXI_RDATA <= {16'h0000, 3'h0, BLOCK_ALARM_O, CONFIG_ERR_I,
                                           DO_BLOCK_ERR_O, vstat};
          `VBIT_RDBK_OFS: S_AXI_RDATA <= {16'h0000, READBACK_O};
          `VBIT_INPUTS_OFS: S_AXI_RDATA <= {flt_pv_reg[1], flt_pv_reg[0], g2_raw_reg, g1_byte};
          `VBIT_ROUTE_OFS: S_AXI_RDATA <= {23'h000000, route_reg};
          `VBIT_ROUTEVAL_OFS: S_AXI_RDATA <= {16'h0000, route_val_reg};
          default: S_AXI_RDATA <= 32'h00000000;
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
  assign S_AXI_BRESP = 2'b00;
  assign S_AXI_RRESP = 2'b00;

  // ======================================================================
  // Millisecond tick
  // One tick paces every slot and filter, keeping timers in step.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tick_cnt_reg <= 17'h00000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_cnt_reg == TICK_LAST;
      tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 17'h00000 : tick_cnt_reg + 17'h00001;
    end
  end

  // ======================================================================
  // Valve coupler
  // A setpoint that is not good keeps the last command but cuts
  // the drive, so the actuator springs to its safety position.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cmd_open_reg <= 1'b0;
      VALVE_DRIVE_O <= 1'b0;
      fb_a_reg <= 1'b0;
      fb_b_reg <= 1'b0;
    end else begin
      fb_a_reg <= FB_A_HIGH_I;
      fb_b_reg <= FB_B_HIGH_I;
      if (is_good(setp_reg.status)) begin
        cmd_open_reg <= setp_reg.value != 8'h00;
      end
      VALVE_DRIVE_O <= valve_mode && is_good(setp_reg.status) && setp_reg.value != 8'h00;
    end
  end

  // Contact decoding: usage 0 A=closed B=open, 1 swapped, 2 only A closed, 3 only B open.
  logic at_open, at_closed;
  always_comb begin
    case (usage)
      2'h0: begin
        at_closed = fb_a_reg;
        at_open = fb_b_reg;
      end
      2'h1: begin
        at_closed = fb_b_reg;
        at_open = fb_a_reg;
      end
      2'h2: begin
        at_closed = fb_a_reg;
        at_open = !fb_a_reg;
      end
      default: begin
        at_closed = !fb_b_reg;
        at_open = fb_b_reg;
      end
    endcase
  end

  // Position, direction and actuation-pending flag.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pos_reg <= POS_INTER;
      ext_reg <= EXT_NONE;
      pending_reg <= 1'b0;
    end else begin
      if (at_open && !at_closed) begin
        pos_reg <= POS_OPEN;
        ext_reg <= EXT_NONE;
      end else if (at_closed && !at_open) begin
        pos_reg <= POS_CLOSED;
        ext_reg <= EXT_NONE;
      end else begin
        pos_reg <= POS_INTER;
        ext_reg <= cmd_open_reg ? EXT_OPENING : EXT_CLOSING;
      end
      // A fresh command wins over reaching the old end position.
      if (is_good(setp_reg.status) && (setp_reg.value != 8'h00) != cmd_open_reg) begin
        pending_reg <= 1'b1;
      end else if ((cmd_open_reg && pos_reg == POS_OPEN) ||
                   (!cmd_open_reg && pos_reg == POS_CLOSED)) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // Readback: setting 0 gives position code, 1 raw contacts.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      READBACK_O <= 16'h0000;
    end else begin
      READBACK_O.value <= ctrl_reg[`VBIT_CTRL_RBGEN_BIT] ? {6'h00, fb_b_reg, fb_a_reg}
                                                         : {6'h00, pos_reg};
      READBACK_O.status <= HW_FAIL_I ? `VBIT_ST_BAD_DEVFAIL :
                           SENSOR_LEAD_FAULT_I ? `VBIT_ST_BAD : `VBIT_ST_GOOD_NC;
    end
  end

  // Faults; a configuration error raises the alarm but is not forwarded.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      BLOCK_ALARM_O <= 1'b0;
      DO_BLOCK_ERR_O <= 3'h0;
    end else begin
      BLOCK_ALARM_O <= VALVE_LEAD_FAULT_I | TRANSIT_FAULT_I | SENSOR_LEAD_FAULT_I |
                       CONFIG_ERR_I | HW_FAIL_I;
      DO_BLOCK_ERR_O.out_fail <= VALVE_LEAD_FAULT_I | TRANSIT_FAULT_I;
      DO_BLOCK_ERR_O.in_fail <= SENSOR_LEAD_FAULT_I;
      DO_BLOCK_ERR_O.dev_fail <= HW_FAIL_I;
    end
  end

  // ======================================================================
  // Binary input scan, group one
  // Disabled channels are skipped in one clock; unpowered ones keep their bit.
  wire logic [15:0] g1_ont = sat_ontime(ont_reg[g1_idx_reg]);
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      g1_idx_reg <= 2'h0;
      g1_cnt_reg <= 16'h0000;
      g1_raw_reg <= 4'h0;
      G1_POWER_O <= 4'h0;
    end else begin
      G1_POWER_O <= (!valve_mode && g1_en[g1_idx_reg]) ? 4'(1 << g1_idx_reg) : 4'h0;
      if (!g1_en[g1_idx_reg]) begin
        g1_idx_reg <= g1_idx_reg + 2'h1;
        g1_cnt_reg <= 16'h0000;
      end else if (tick_reg) begin
        if (g1_cnt_reg == g1_ont - 16'h0001) begin
          g1_raw_reg[g1_idx_reg] <= valve_mode ? g1_raw_reg[g1_idx_reg] : G1_SENSE_HIGH_I;
          g1_idx_reg <= g1_idx_reg + 2'h1;
          g1_cnt_reg <= 16'h0000;
        end else begin
          g1_cnt_reg <= g1_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // ======================================================================
  // Binary input scan, group two
  // Short cycles are padded with idle slots to the minimum length.
  wire logic g2_slot_end = tick_reg && g2_cnt_reg == G2_SLOT_LAST;
  wire logic g2_adv = !g2_en[g2_idx_reg] || g2_slot_end;
  wire logic [3:0] g2_used_after = g2_used_reg + {3'h0, g2_en[g2_idx_reg]};
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      g2_state_reg <= G2_SCAN;
      g2_idx_reg <= 3'h0;
      g2_cnt_reg <= 4'h0;
      g2_used_reg <= 4'h0;
      g2_pad_reg <= 4'h0;
      g2_raw_reg <= 8'h00;
      G2_SELECT_O <= 8'h00;
    end else begin
      G2_SELECT_O <= (g2_state_reg == G2_SCAN && g2_en[g2_idx_reg]) ?
                     8'(1 << g2_idx_reg) : 8'h00;
      if (tick_reg) begin
        g2_cnt_reg <= (g2_cnt_reg == G2_SLOT_LAST) ? 4'h0 : g2_cnt_reg + 4'h1;
      end
      case (g2_state_reg)
        G2_SCAN: begin
          if (!g2_en[g2_idx_reg]) begin
            g2_cnt_reg <= 4'h0;
          end
          if (g2_slot_end && g2_en[g2_idx_reg]) begin
            g2_raw_reg[g2_idx_reg] <= G2_SENSE_HIGH_I;
          end
          if (g2_adv) begin
            g2_idx_reg <= g2_idx_reg + 3'h1;
            g2_used_reg <= g2_used_after;
            if (g2_idx_reg == 3'h7) begin
              g2_used_reg <= 4'h0;
              if (g2_used_after < G2_MIN_SLOTS) begin
                g2_state_reg <= G2_PAD;
                g2_pad_reg <= G2_MIN_SLOTS - g2_used_after;
              end
            end
          end
        end
        G2_PAD: begin
          if (g2_slot_end) begin
            g2_pad_reg <= g2_pad_reg - 4'h1;
            if (g2_pad_reg == 4'h1) begin
              g2_state_reg <= G2_SCAN;
            end
          end
        end
        default: g2_state_reg <= G2_SCAN;
      endcase
    end
  end

  // ======================================================================
  // Stability filter
  // Any change restarts the wait; with a zero time values pass at once.
  wire logic [7:0] flt_in [2] = '{g1_byte, g2_raw_reg};
  wire logic [25:0] flt_lim = 26'(ftime_reg) * `VBIT_SEC_MS;
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      flt_last_reg <= '{default: 8'h00};
      flt_pv_reg <= '{default: 8'h00};
      flt_cnt_reg <= '{default: 26'h0000000};
    end else begin
      for (int g = 0; g < 2; g++) begin
        flt_last_reg[g] <= flt_in[g];
        if (flt_in[g] != flt_last_reg[g]) begin
          flt_cnt_reg[g] <= 26'h0000000;
        end else if (flt_cnt_reg[g] >= flt_lim) begin
          flt_pv_reg[g] <= flt_last_reg[g];
        end else if (tick_reg) begin
          flt_cnt_reg[g] <= flt_cnt_reg[g] + 26'h0000001;
        end
      end
    end
  end

  // ======================================================================
  // Channel routing
  // Packed groups ignore lead faults; only device failure makes them bad.
  wire logic [8:0] g1_ch = route_reg - `VBIT_CH_G1_FIRST;
  wire logic [8:0] g2_ch = route_reg - `VBIT_CH_G2_FIRST;
  wire logic [7:0] pk_st = HW_FAIL_I ? `VBIT_ST_BAD_DEVFAIL : `VBIT_ST_GOOD_NC;
  wire logic [7:0] ind_st = (HW_FAIL_I || SENSOR_LEAD_FAULT_I) ? `VBIT_ST_BAD : `VBIT_ST_GOOD_NC;
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      route_val_reg <= 16'h0000;
    end else if (route_reg >= `VBIT_CH_G1_FIRST && route_reg <= `VBIT_CH_G1_LAST) begin
      route_val_reg <= {ind_st, 7'h00, flt_pv_reg[0][g1_ch[1:0]]};
    end else if (route_reg >= `VBIT_CH_G2_FIRST && route_reg <= `VBIT_CH_G2_LAST) begin
      route_val_reg <= {ind_st, 7'h00, flt_pv_reg[1][g2_ch[2:0]]};
    end else if (route_reg == `VBIT_CH_G1_BYTE) begin
      route_val_reg <= {ind_st, flt_pv_reg[0]};
    end else if (route_reg == `VBIT_CH_G2_BYTE) begin
      route_val_reg <= {ind_st, flt_pv_reg[1]};
    end else if (route_reg == `VBIT_CH_G1_PACKED) begin
      route_val_reg <= {pk_st, flt_pv_reg[0]};
    end else if (route_reg == `VBIT_CH_G2_PACKED) begin
      route_val_reg <= {pk_st, flt_pv_reg[1]};
    end else begin
      route_val_reg <= {`VBIT_ST_BAD, 8'h00};
    end
  end
endmodule

// File: rtl/vbit_map.svh
// Offsets, fields, reset values and timing counts of the transducer.
`ifndef VBIT_MAP_SVH
`define VBIT_MAP_SVH
`define VBIT_CTRL_OFS 8'h00
`define VBIT_SETP_OFS 8'h04
`define VBIT_ONT01_OFS 8'h08
`define VBIT_ONT23_OFS 8'h0C
`define VBIT_FTIME_OFS 8'h10
`define VBIT_VSTAT_OFS 8'h14
`define VBIT_RDBK_OFS 8'h18
`define VBIT_INPUTS_OFS 8'h1C
`define VBIT_ROUTE_OFS 8'h20
`define VBIT_ROUTEVAL_OFS 8'h24
`define VBIT_CTRL_MODE_BIT 0
`define VBIT_CTRL_USAGE_LSB 1
`define VBIT_CTRL_RBGEN_BIT 3
`define VBIT_CTRL_G1EN_LSB 4
`define VBIT_CTRL_G2EN_LSB 8
`define VBIT_CTRL_RST 32'h0000FFF0
`define VBIT_ONT_RST 16'h000A
`define VBIT_FTIME_RST 16'h0000
`define VBIT_ROUTE_RST 9'h000
`define VBIT_ST_GOOD_NC 8'h80
`define VBIT_ST_BAD_DEVFAIL 8'h0C
`define VBIT_ST_BAD 8'h00
`define VBIT_Q_GOOD_NC 2'h2
`define VBIT_Q_GOOD_CAS 2'h3
`define VBIT_CLK_PERIOD_NS 10
`define VBIT_TICK_TIME_NS 1000000
`define VBIT_ONT_MIN_MS 16'd10
`define VBIT_ONT_MAX_MS 16'd11000
`define VBIT_G2_SLOT_MS 10
`define VBIT_G2_MIN_CYCLE_MS 50
`define VBIT_SEC_MS 26'd1000
`define VBIT_CH_G1_BYTE 9'd300
`define VBIT_CH_G1_FIRST 9'd301
`define VBIT_CH_G1_LAST 9'd304
`define VBIT_CH_G1_PACKED 9'd305
`define VBIT_CH_G2_BYTE 9'd200
`define VBIT_CH_G2_FIRST 9'd201
`define VBIT_CH_G2_LAST 9'd208
`define VBIT_CH_G2_PACKED 9'd5
`endif

// File: rtl/vbit_pkg.sv
// Types shared by the valve and binary input transducer.
package vbit_pkg;
  typedef enum logic [1:0] {
    POS_CLOSED = 2'b00,
    POS_OPEN = 2'b01,
    POS_INTER = 2'b10
  } vbit_pos_e;
  typedef enum logic [1:0] {
    EXT_NONE = 2'b00,
    EXT_OPENING = 2'b01,
    EXT_CLOSING = 2'b10
  } vbit_ext_e;
  typedef enum logic {
    G2_SCAN = 1'b0,
    G2_PAD = 1'b1
  } vbit_g2_e;
  // Value with its fieldbus status byte.
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] value;
  } vbit_val_s;
  // Faults forwarded to the output block.
  typedef struct packed {
    logic dev_fail;
    logic in_fail;
    logic out_fail;
  } vbit_err_s;
endpackage

// File: verif/vbit_props.sv
// Port assertions for the transducer.
`timescale 1ns/1ps
module vbit_props (
  input wire logic CLK_SYS_I, // Clock.
  input wire logic ARST_N_I, // Reset.
  input wire logic VALVE_LEAD_FAULT_I, // Fault.
  input wire logic TRANSIT_FAULT_I, // Fault.
  input wire logic SENSOR_LEAD_FAULT_I, // Fault.
  input wire logic CONFIG_ERR_I, // Fault.
  input wire logic HW_FAIL_I, // Fault.
  input wire logic [3:0] G1_POWER_O, // Power.
  input wire logic [7:0] G2_SELECT_O, // Select.
  input wire logic BLOCK_ALARM_O, // Alarm.
  input wire vbit_pkg::vbit_err_s DO_BLOCK_ERR_O, // Errors.
  input wire vbit_pkg::vbit_val_s READBACK_O // Readback.
);
  import vbit_pkg::*;
  // ==========
  // Checks
  // One domain: clock and reset declared once.
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!ARST_N_I);
  logic out_f;
  logic hard_f;
  // Faults forwarded as output failure.
  assign out_f = VALVE_LEAD_FAULT_I || TRANSIT_FAULT_I;
  assign hard_f = out_f || SENSOR_LEAD_FAULT_I || HW_FAIL_I;
  property p_alarm; BLOCK_ALARM_O == $past(hard_f || CONFIG_ERR_I); endproperty
  a_alarm: assert property (p_alarm) else $error("alarm wrong");
  property p_out; out_f [*2] |-> DO_BLOCK_ERR_O.out_fail; endproperty
  a_out: assert property (p_out) else $error("no out fail");
  property p_in; SENSOR_LEAD_FAULT_I [*2] |-> DO_BLOCK_ERR_O.in_fail; endproperty
  a_in: assert property (p_in) else $error("no in fail");
  property p_cfg; !hard_f [*2] |-> DO_BLOCK_ERR_O == 3'h0; endproperty
  a_cfg: assert property (p_cfg) else $error("stray error");
  property p_rbhw; HW_FAIL_I [*3] |-> READBACK_O.status == 8'h0C; endproperty
  a_rbhw: assert property (p_rbhw) else $error("bad status");
  property p_rbok; !(SENSOR_LEAD_FAULT_I || HW_FAIL_I) [*3] |-> READBACK_O.status == 8'h80;
  endproperty
  a_rbok: assert property (p_rbok) else $error("good status");
  property p_g1; $onehot0(G1_POWER_O); endproperty
  a_g1: assert property (p_g1) else $error("g1 power");
  property p_g2; $rose(G2_SELECT_O[0]) |=> G2_SELECT_O[0] [*8]; endproperty
  a_g2: assert property (p_g2) else $error("g2 slot");
endmodule

// File: verif/vbit_field_model.sv
// Valve, contacts and multiplexed sensors outside the transducer.
`timescale 1ns/1ps
module vbit_field_model (
  input wire logic clk_i, // Clock.
  input wire logic drive_i, // Valve drive.
  input wire logic [3:0] g1_pow_i, // Group one power.
  input wire logic [7:0] g2_sel_i, // Group two select.
  output logic fb_a_o, // Closed contact.
  output logic fb_b_o, // Open contact.
  output logic g1_sense_o, // Group one sense.
  output logic g2_sense_o // Group two sense.
);
  // ==========
  // Field
  logic [5:0] travel_reg = 6'h0;
  logic idle_reg = 1'h0;
  // A slow stroke shows the valve between its ends.
  always_ff @(posedge clk_i) begin
    idle_reg <= ~idle_reg;
    if (drive_i && travel_reg != 6'h28) begin
      travel_reg <= travel_reg + 6'h1;
    end else if (!drive_i && travel_reg != 6'h0) begin
      travel_reg <= travel_reg - 6'h1;
    end
  end
  // Unpowered sense lines float, so they toggle rather than hold.
  assign fb_a_o = travel_reg == 6'h0;
  assign fb_b_o = travel_reg == 6'h28;
  assign g1_sense_o = g1_pow_i == 4'h0 ? idle_reg : |(g1_pow_i & 4'h9);
  assign g2_sense_o = g2_sel_i == 8'h0 ? idle_reg : |(g2_sel_i & 8'hA5);
endmodule

// File: verif/test_vbit_transducer.sv
// Self-checking bench for the transducer.
`timescale 1ns/1ps
`include "vbit_map.svh"
module test_vbit_transducer;
  import vbit_pkg::*;
  // ==========
  // Signals
  logic CLK_SYS_I = 1'h0, ARST_N_I = 1'h0, S_AXI_BREADY = 1'h0, S_AXI_RREADY = 1'h0;
  logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_ARVALID = 1'h0;
  logic [7:0] S_AXI_AWADDR = 8'h0, S_AXI_ARADDR = 8'h0, G2_SELECT_O;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hF, G1_POWER_O;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic FB_A_HIGH_I, FB_B_HIGH_I, G1_SENSE_HIGH_I, G2_SENSE_HIGH_I, VALVE_DRIVE_O, BLOCK_ALARM_O;
  vbit_err_s DO_BLOCK_ERR_O;
  vbit_val_s READBACK_O;
  logic [6:0] flt = 7'h0;
  wire VALVE_LEAD_FAULT_I = flt[0], TRANSIT_FAULT_I = flt[1], SENSOR_LEAD_FAULT_I = flt[2];
  wire CONFIG_ERR_I = flt[3], HW_FAIL_I = flt[4], STROKE_LIMIT_I = flt[5];
  wire CYCLIC_TEST_I = flt[6];
  logic [15:0] sp [4] = '{16'h8005, 16'h4005, 16'hC000, 16'hC003};
  logic [15:0] ft [7] = '{16'h8880, 16'h8880, 16'h9080, 16'hC080, 16'hA00C, 16'h0180, 16'h0280};
  logic [19:0] rt [6] = '{20'h13109, 20'h005A5, 20'h12C09, 20'h0C8A5, 20'h13001, 20'h0CF00};
  int fails = 0, compares = 0;
  // A short tick keeps the millisecond scans affordable.
  vbit_transducer #(.TICK_CYCLES(10)) uut (.*);
  vbit_field_model u_field (.clk_i(CLK_SYS_I), .drive_i(VALVE_DRIVE_O), .g1_pow_i(G1_POWER_O),
    .g2_sel_i(G2_SELECT_O), .fb_a_o(FB_A_HIGH_I), .fb_b_o(FB_B_HIGH_I),
    .g1_sense_o(G1_SENSE_HIGH_I), .g2_sense_o(G2_SENSE_HIGH_I));
  initial forever #5 CLK_SYS_I = ~CLK_SYS_I;
  // AXI write; each channel drops once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK_SYS_I);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    do begin
      @(posedge CLK_SYS_I);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
    end while (S_AXI_BVALID !== 1'h1);
    S_AXI_BREADY <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // AXI read, masked and compared.
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge CLK_SYS_I);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    do begin
      @(posedge CLK_SYS_I);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
    end while (S_AXI_RVALID !== 1'h1);
    S_AXI_RREADY <= 1'h0;
    chk(S_AXI_RDATA & m, e);
  endtask
  wire logic [1:0] first_ch = {G2_SELECT_O[0], G1_POWER_O[0]};
  // Scan period, rise to rise of the first channel; the first lap only aligns.
  task automatic meas(input bit g2, input int e);
    int c;
    c = 0;
    for (int k = 0; k < 4; k++) begin
      while (first_ch[g2] !== k[0]) begin
        @(posedge CLK_SYS_I);
        c += (k > 1);
      end
    end
    compares++;
    if (c < e - 15 || c > e + 15) begin
      fails++;
      $display("[FAIL] %0t period %0d want %0d", $time, c, e);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge CLK_SYS_I);
    fails++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge CLK_SYS_I);
    ARST_N_I <= 1'h1;
    rc(`VBIT_CTRL_OFS, '1, 32'h0000FFF0);
    rc(`VBIT_FTIME_OFS, '1, 32'h0);
    rc(8'h40, '1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`VBIT_SETP_OFS, {16'h0, sp[i]});
      repeat (4) @(posedge CLK_SYS_I);
      chk(VALVE_DRIVE_O, (i == 0 || i == 3));
    end
    rc(`VBIT_VSTAT_OFS, 32'h8F, 32'h86);
    repeat (80) @(posedge CLK_SYS_I);
    rc(`VBIT_VSTAT_OFS, 32'h8F, 32'h01);
    chk(READBACK_O, 16'h8001);
    wr(`VBIT_ROUTE_OFS, 32'd305);
    for (int i = 0; i < 7; i++) begin
      flt <= 7'h1 << i;
      repeat (4) @(posedge CLK_SYS_I);
      rc(`VBIT_VSTAT_OFS, 32'h1FE0, {19'h0, ft[i][15:8], 5'h0});
      rc(`VBIT_ROUTEVAL_OFS, 32'hFF00, {16'h0, ft[i][7:0], 8'h0});
    end
    flt <= 7'h0;
    wr(`VBIT_CTRL_OFS, 32'h0000FFB1);
    wr(`VBIT_ONT01_OFS, 32'h000C000A);
    wr(`VBIT_ONT23_OFS, 32'h00050014);
    meas(1'h1, 800);
    meas(1'h0, 320);
    rc(`VBIT_INPUTS_OFS, '1, 32'hA509A509);
    for (int i = 0; i < 6; i++) begin
      wr(`VBIT_ROUTE_OFS, {20'h0, rt[i][19:8]});
      rc(`VBIT_ROUTEVAL_OFS, 32'hFF, {24'h0, rt[i][7:0]});
    end
    wr(`VBIT_CTRL_OFS, 32'h000003BB);
    meas(1'h1, 500);
    rc(`VBIT_VSTAT_OFS, 32'hF, 32'h1);
    chk(READBACK_O, 16'h8001);
    give_verdict();
  end
endmodule
bind vbit_transducer vbit_props u_props (.*);
